/* File: logic/afd_params.svh */
// Constants for the ALU flag and direct addressing block.
// Assumes an 8-bit data path and a 12-bit data memory address.
`ifndef AFD_PARAMS_SVH
`define AFD_PARAMS_SVH

// ----------------------------------------
// Flag register layout
// ----------------------------------------
`define AFD_FLAGS_W      5
`define AFD_FLAG_C       0
`define AFD_FLAG_DC      1
`define AFD_FLAG_Z       2
`define AFD_FLAG_OV      3
`define AFD_FLAG_N       4
`define AFD_FLAGS_RST    5'h00

// ----------------------------------------
// Data memory map
// ----------------------------------------
`define AFD_FLAGS_ADDR   12'hFF0
`define AFD_ACCESS_SPLIT 8'h60
`define AFD_ACCESS_HI    4'hF
`define AFD_ACCESS_LO    4'h0
`define AFD_INDEX_MAX    8'h5F

// ----------------------------------------
// Register port map
// ----------------------------------------
`define AFD_REG_AW       3
`define AFD_REG_FLAGS    3'h0
`define AFD_REG_BANK     3'h1
`define AFD_REG_ACC      3'h2
`define AFD_REG_CTRL     3'h3
`define AFD_REG_STATE    3'h4
`define AFD_REG_ADDR_LO  3'h5
`define AFD_REG_ADDR_HI  3'h6
`define AFD_CTRL_EXT     0
`define AFD_BANK_RST     4'h0
`define AFD_ACC_RST      8'h00

`endif

/* File: logic/afd_pkg.sv */
// Types for the ALU flag and direct addressing block.
// Assumes the constants header is included by users of numbers.
package afd_pkg;

    typedef enum logic [3:0] {
        OP_NOP       = 4'h0,
        OP_ADD_WF    = 4'h1,
        OP_SUB_WF    = 4'h2,
        OP_AND_WF    = 4'h3,
        OP_IOR_WF    = 4'h4,
        OP_XOR_WF    = 4'h5,
        OP_MOV_F     = 4'h6,
        OP_CLR_F     = 4'h7,
        OP_NIB_SWAP  = 4'h8,
        OP_BIT_CLEAR = 4'h9,
        OP_BIT_SET   = 4'hA,
        OP_ACC_STORE = 4'hB,
        OP_FULL_MOVE = 4'hC,
        OP_ADD_LW    = 4'hD,
        OP_SUB_LW    = 4'hE,
        OP_JUMP      = 4'hF
    } afd_op_t;

    typedef enum logic [2:0] {
        FK_NONE  = 3'b000,
        FK_ADD   = 3'b001,
        FK_SUB   = 3'b010,
        FK_LOGIC = 3'b011,
        FK_ZERO  = 3'b100
    } afd_fkind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b10
    } afd_state_t;

endpackage

/* File: logic/afd_alu_if.sv */
// Operand and flag bundle between the core and its flag unit.
// Assumes both ends share the core clock; the unit is combinational.
`timescale 1ns/10ps
`include "afd_params.svh"

interface afd_alu_if;
    import afd_pkg::*;
    logic [7:0]               op_a;
    logic [7:0]               op_b;
    afd_fkind_t               kind;
    logic [7:0]               result;
    logic [`AFD_FLAGS_W-1:0]  flags_new;
    logic [`AFD_FLAGS_W-1:0]  flags_mask;

    modport core (output op_a, op_b, kind, input result, flags_new, flags_mask);
    modport unit (input op_a, op_b, kind, output result, flags_new, flags_mask);
endinterface

/* File: logic/afd_flag_unit.sv */
// Adder and flag generator for the ALU.
// Assumes the core presents logic results already formed in op_a.
`timescale 1ns/10ps
`include "afd_params.svh"

module afd_flag_unit (
    afd_alu_if.unit alu
);
    import afd_pkg::*;

    logic       is_sub;
    logic [7:0] b_eff;
    logic [8:0] sum;
    logic [4:0] low_sum;

    // ----------------------------------------
    // Arithmetic
    // ----------------------------------------
    assign is_sub  = (alu.kind == FK_SUB);
    assign b_eff   = is_sub ? ~alu.op_b : alu.op_b;
    assign sum     = {1'b0, alu.op_a} + {1'b0, b_eff} + {8'h00, is_sub};
    assign low_sum = {1'b0, alu.op_a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, is_sub};

    // ----------------------------------------
    // Flags
    // ----------------------------------------
    always_comb begin
        alu.result     = alu.op_a;
        alu.flags_new  = `AFD_FLAGS_RST;
        alu.flags_mask = `AFD_FLAGS_RST;
        unique case (alu.kind)
            FK_ADD, FK_SUB: begin
                alu.result                = sum[7:0];
                alu.flags_mask            = 5'h1F;
                alu.flags_new[`AFD_FLAG_N]  = sum[7];
                alu.flags_new[`AFD_FLAG_OV] = (alu.op_a[7] == b_eff[7])
                                              && (sum[7] != alu.op_a[7]);
                alu.flags_new[`AFD_FLAG_Z]  = (sum[7:0] == 8'h00);
                alu.flags_new[`AFD_FLAG_DC] = low_sum[4];
                alu.flags_new[`AFD_FLAG_C]  = sum[8];
            end
            FK_LOGIC: begin
                alu.flags_mask[`AFD_FLAG_N] = 1'b1;
                alu.flags_mask[`AFD_FLAG_Z] = 1'b1;
                alu.flags_new[`AFD_FLAG_N]  = alu.op_a[7];
                alu.flags_new[`AFD_FLAG_Z]  = (alu.op_a == 8'h00);
            end
            FK_ZERO: begin
                alu.flags_mask[`AFD_FLAG_Z] = 1'b1;
                alu.flags_new[`AFD_FLAG_Z]  = 1'b1;
            end
            FK_NONE: begin
                alu.flags_mask = `AFD_FLAGS_RST;
            end
            default: begin
                alu.flags_mask = `AFD_FLAGS_RST;
            end
        endcase
    end
endmodule

/* File: logic/afd_core.sv */
// ALU flag register and direct data addressing for an 8-bit core.
// Assumes banked memory answers a read one cycle after mem_re.
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/10ps
`include "afd_params.svh"

module afd_core (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire logic [`AFD_REG_AW-1:0]   reg_addr,
    input  wire logic [7:0]               reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [7:0]               reg_rdata,
    input  wire logic                     instr_valid,
    input  wire afd_pkg::afd_op_t         instr_op,
    input  wire logic [7:0]               instr_faddr,
    input  wire logic                     instr_access,
    input  wire logic                     instr_dest,
    input  wire logic [2:0]               instr_bit,
    input  wire logic [7:0]               instr_lit,
    input  wire logic [11:0]              instr_src_full,
    input  wire logic [11:0]              instr_dst_full,
    input  wire logic [19:0]              instr_target,
    input  wire logic [11:0]              index_base,
    output logic                          instr_ready,
    output logic                          instr_done,
    output logic      [11:0]              mem_addr,
    output logic                          mem_re,
    output logic                          mem_we,
    output logic      [7:0]               mem_wdata,
    input  wire logic [7:0]               mem_rdata,
    output logic      [19:0]              pc_target,
    output logic                          pc_load,
    output logic      [`AFD_FLAGS_W-1:0]  alu_flags,
    output logic      [7:0]               acc
);
    import afd_pkg::*;

    afd_alu_if alu ();

    afd_flag_unit u_flag_unit (
        .alu (alu.unit)
    );

    // ----------------------------------------
    // Address formation
    // ----------------------------------------
    function automatic logic [11:0] direct_addr(
        input logic [7:0] faddr,
        input logic       access,
        input logic [3:0] bank,
        input logic       ext_en,
        input logic [11:0] base
    );
        logic [11:0] addr;
        addr = {bank, faddr};
        if (!access) begin
            if (ext_en && (faddr <= `AFD_INDEX_MAX)) begin
                addr = base + {4'h0, faddr};
            end else if (faddr < `AFD_ACCESS_SPLIT) begin
                addr = {`AFD_ACCESS_LO, faddr};
            end else begin
                addr = {`AFD_ACCESS_HI, faddr};
            end
        end
        return addr;
    endfunction

    function automatic logic needs_read(input afd_op_t op);
        return (op inside {OP_ADD_WF, OP_SUB_WF, OP_AND_WF, OP_IOR_WF, OP_XOR_WF,
                           OP_MOV_F, OP_NIB_SWAP, OP_BIT_CLEAR, OP_BIT_SET,
                           OP_FULL_MOVE});
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    afd_state_t   state;
    afd_op_t      op_q;
    logic [11:0]  src_addr_q;
    logic [11:0]  dst_addr_q;
    logic         dest_q;
    logic [2:0]   bit_q;
    logic [7:0]   lit_q;
    logic [19:0]  target_q;
    logic [3:0]   bank_select_reg;
    logic         extended_set_enable;
    logic [11:0]  last_addr;

    logic [11:0]  next_src_addr;
    logic [7:0]   opnd;
    logic [7:0]   next_res;
    logic         next_to_file;
    logic         next_to_acc;
    logic [11:0]  next_wb_addr;
    logic         wb_is_flags;
    logic         exec;

    assign exec = (state == ST_EXEC);

    always_comb begin
        next_src_addr = direct_addr(instr_faddr, instr_access, bank_select_reg,
                                    extended_set_enable, index_base);
        if (instr_op == OP_FULL_MOVE) begin
            next_src_addr = instr_src_full;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state       <= ST_IDLE;
            instr_ready <= 1'b1;
            instr_done  <= 1'b0;
            mem_re      <= 1'b0;
        end else begin
            instr_done <= 1'b0;
            mem_re     <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (instr_valid) begin
                        instr_ready <= 1'b0;
                        if (needs_read(instr_op)) begin
                            state  <= ST_READ;
                            mem_re <= 1'b1;
                        end else begin
                            state <= ST_EXEC;
                        end
                    end
                end
                ST_READ: begin
                    state <= ST_EXEC;
                end
                ST_EXEC: begin
                    state       <= ST_IDLE;
                    instr_done  <= 1'b1;
                    instr_ready <= 1'b1;
                end
                default: begin
                    state       <= ST_IDLE;
                    instr_ready <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            op_q       <= OP_NOP;
            src_addr_q <= 12'h000;
            dst_addr_q <= 12'h000;
            dest_q     <= 1'b0;
            bit_q      <= 3'h0;
            lit_q      <= 8'h00;
            target_q   <= 20'h0_0000;
        end else if ((state == ST_IDLE) && instr_valid) begin
            op_q       <= instr_op;
            src_addr_q <= next_src_addr;
            dst_addr_q <= (instr_op == OP_FULL_MOVE) ? instr_dst_full
                                                     : next_src_addr;
            dest_q     <= instr_dest;
            bit_q      <= instr_bit;
            lit_q      <= instr_lit;
            target_q   <= instr_target;
        end
    end

    // ----------------------------------------
    // Execute
    // ----------------------------------------
    assign opnd = (src_addr_q == `AFD_FLAGS_ADDR) ? {3'b000, alu_flags} : mem_rdata;

    always_comb begin
        alu.op_a     = opnd;
        alu.op_b     = acc;
        alu.kind     = FK_NONE;
        next_res     = opnd;
        next_to_file = 1'b0;
        next_to_acc  = 1'b0;
        unique case (op_q)
            OP_ADD_WF, OP_SUB_WF: begin
                alu.kind     = (op_q == OP_SUB_WF) ? FK_SUB : FK_ADD;
                next_res     = alu.result;
                next_to_file = dest_q;
                next_to_acc  = !dest_q;
            end
            OP_AND_WF, OP_IOR_WF, OP_XOR_WF, OP_MOV_F: begin
                if (op_q == OP_AND_WF) begin
                    alu.op_a = opnd & acc;
                end else if (op_q == OP_IOR_WF) begin
                    alu.op_a = opnd | acc;
                end else if (op_q == OP_XOR_WF) begin
                    alu.op_a = opnd ^ acc;
                end
                alu.kind     = FK_LOGIC;
                next_res     = alu.result;
                next_to_file = dest_q;
                next_to_acc  = !dest_q;
            end
            OP_CLR_F: begin
                alu.op_a     = 8'h00;
                alu.kind     = FK_ZERO;
                next_res     = 8'h00;
                next_to_file = 1'b1;
            end
            OP_NIB_SWAP: begin
                next_res     = {opnd[3:0], opnd[7:4]};
                next_to_file = dest_q;
                next_to_acc  = !dest_q;
            end
            OP_BIT_CLEAR, OP_BIT_SET: begin
                next_res         = opnd;
                next_res[bit_q]  = (op_q == OP_BIT_SET);
                next_to_file     = 1'b1;
            end
            OP_ACC_STORE: begin
                next_res     = acc;
                next_to_file = 1'b1;
            end
            OP_FULL_MOVE: begin
                next_res     = opnd;
                next_to_file = 1'b1;
            end
            OP_ADD_LW, OP_SUB_LW: begin
                alu.op_a    = lit_q;
                alu.kind    = (op_q == OP_SUB_LW) ? FK_SUB : FK_ADD;
                next_res    = alu.result;
                next_to_acc = 1'b1;
            end
            OP_NOP, OP_JUMP: begin
                next_res = opnd;
            end
        endcase
    end

    assign next_wb_addr = dst_addr_q;
    assign wb_is_flags  = next_to_file && (next_wb_addr == `AFD_FLAGS_ADDR);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mem_we    <= 1'b0;
            mem_addr  <= 12'h000;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            if ((state == ST_IDLE) && instr_valid) begin
                mem_addr <= next_src_addr;
            end else if (exec && next_to_file && !wb_is_flags) begin
                mem_we    <= 1'b1;
                mem_addr  <= next_wb_addr;
                mem_wdata <= next_res;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pc_load   <= 1'b0;
            pc_target <= 20'h0_0000;
        end else begin
            pc_load <= exec && (op_q == OP_JUMP);
            if (exec && (op_q == OP_JUMP)) begin
                pc_target <= target_q;
            end
        end
    end

    // ----------------------------------------
    // Flag register and accumulator
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            alu_flags <= `AFD_FLAGS_RST;
        end else if (exec && wb_is_flags && (alu.kind == FK_NONE)) begin
            alu_flags <= next_res[`AFD_FLAGS_W-1:0];
        end else if (exec && (alu.kind != FK_NONE)) begin
            alu_flags <= (alu_flags & ~alu.flags_mask)
                         | (alu.flags_new & alu.flags_mask);
        end else if (reg_wr && (reg_addr == `AFD_REG_FLAGS)) begin
            alu_flags <= reg_wdata[`AFD_FLAGS_W-1:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            acc <= `AFD_ACC_RST;
        end else if (exec && next_to_acc) begin
            acc <= next_res;
        end else if (reg_wr && (reg_addr == `AFD_REG_ACC)) begin
            acc <= reg_wdata;
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bank_select_reg     <= `AFD_BANK_RST;
            extended_set_enable <= 1'b0;
        end else if (reg_wr) begin
            if (reg_addr == `AFD_REG_BANK) begin
                bank_select_reg <= reg_wdata[3:0];
            end
            if (reg_addr == `AFD_REG_CTRL) begin
                extended_set_enable <= reg_wdata[`AFD_CTRL_EXT];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            last_addr <= 12'h000;
        end else if ((state == ST_IDLE) && instr_valid) begin
            last_addr <= next_src_addr;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= 8'h00;
            if (reg_rd) begin
                unique case (reg_addr)
                    `AFD_REG_FLAGS:   reg_rdata <= {3'b000, alu_flags};
                    `AFD_REG_BANK:    reg_rdata <= {4'h0, bank_select_reg};
                    `AFD_REG_ACC:     reg_rdata <= acc;
                    `AFD_REG_CTRL:    reg_rdata <= {7'h00, extended_set_enable};
                    `AFD_REG_STATE:   reg_rdata <= {6'h00, state};
                    `AFD_REG_ADDR_LO: reg_rdata <= last_addr[7:0];
                    `AFD_REG_ADDR_HI: reg_rdata <= {4'h0, last_addr[11:8]};
                    default:          reg_rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule

/* File: sim/afd_mem_model.sv */
// Banked data memory model at the far side of the core.
// Assumes one clock; read data is valid only in the cycle after mem_re.
`timescale 1ns/10ps

module afd_mem_model (
    input  wire logic        clk_sys,
    input  wire logic [11:0] mem_addr,
    input  wire logic        mem_re,
    input  wire logic        mem_we,
    input  wire logic [7:0]  mem_wdata,
    output logic      [7:0]  mem_rdata
);
    logic [7:0] mem [4096];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = i[7:0];
        end
        mem_rdata = 8'hA5;
    end
    // Data toggles outside a read answer.
    always @(posedge clk_sys) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
        if (mem_re) begin
            mem_rdata <= mem[mem_addr];
        end else begin
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

/* File: sim/afd_core_monitor.sv */
// Concurrent checks on the core ports.
// Assumes it is bound to afd_core and sees only its ports.
`timescale 1ns/10ps
`include "afd_params.svh"

module afd_core_monitor (
    input wire logic                   clk_sys,
    input wire logic                   rst_b,
    input wire logic [`AFD_REG_AW-1:0] reg_addr,
    input wire logic [7:0]             reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   instr_valid,
    input wire afd_pkg::afd_op_t       instr_op,
    input wire logic [7:0]             instr_faddr,
    input wire logic                   instr_access,
    input wire logic                   instr_dest,
    input wire logic [11:0]            instr_src_full,
    input wire logic [11:0]            instr_dst_full,
    input wire logic [19:0]            instr_target,
    input wire logic                   instr_ready,
    input wire logic                   instr_done,
    input wire logic [11:0]            mem_addr,
    input wire logic                   mem_re,
    input wire logic                   mem_we,
    input wire logic [19:0]            pc_target,
    input wire logic                   pc_load,
    input wire logic [`AFD_FLAGS_W-1:0] alu_flags,
    input wire logic [7:0]             acc
);
    import afd_pkg::*;
    logic [3:0] bank_shadow;
    logic       take;
    logic       hi_acc;
    assign take = instr_valid && instr_ready;
    assign hi_acc = !instr_access && instr_faddr >= 8'h60 && instr_faddr != 8'hF0;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bank_shadow <= 4'h0;
        end else if (reg_wr && reg_addr == `AFD_REG_BANK) begin
            bank_shadow <= reg_wdata[3:0];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_take(afd_op_t o);
        take && instr_op == o;
    endsequence
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    read_time_a: assert property (s_take(OP_ADD_WF) |=> mem_re ##2 instr_done)
        else $error("file op late");
    lit_flags_a: assert property (s_take(OP_ADD_LW) |-> ##2 instr_done &&
        alu_flags[`AFD_FLAG_N] == acc[7] && alu_flags[`AFD_FLAG_Z] == (acc == 8'h00))
        else $error("sign or zero flag wrong");
    access_hi_a: assert property (take && hi_acc && instr_op inside {OP_ADD_WF, OP_NIB_SWAP}
        |=> mem_addr == {4'hF, $past(instr_faddr)})
        else $error("upper access page wrong");
    bank_join_a: assert property (s_take(OP_ADD_WF) ##0 instr_access
        |=> mem_addr == {bank_shadow, $past(instr_faddr)})
        else $error("bank not joined");
    full_move_a: assert property (s_take(OP_FULL_MOVE) ##0 instr_dst_full != `AFD_FLAGS_ADDR
        |=> mem_addr == $past(instr_src_full) ##2 mem_we && mem_addr == $past(instr_dst_full, 3))
        else $error("full move address wrong");
    dest_acc_a: assert property (s_take(OP_ADD_WF) ##0 !instr_dest |=> !mem_we [*3])
        else $error("file written for acc dest");
    dest_file_a: assert property (s_take(OP_ADD_WF)
        ##0 (instr_dest && instr_access && bank_shadow != 4'hF) |=> ##2 mem_we && $stable(mem_addr))
        else $error("no write back");
    flag_dest_a: assert property (s_take(OP_ADD_WF)
        ##0 (!instr_access && instr_faddr == 8'hF0) |=> !mem_we [*3])
        else $error("flag target written");
    keep_flags_a: assert property (@(posedge clk_sys) disable iff (!rst_b || reg_wr)
        s_take(OP_NIB_SWAP) ##0 hi_acc |=> $stable(alu_flags) [*3])
        else $error("swap changed flags");
    jump_load_a: assert property (s_take(OP_JUMP)
        |-> ##2 pc_load && pc_target == $past(instr_target, 2))
        else $error("jump target not loaded");
endmodule

bind afd_core afd_core_monitor afd_core_monitor_inst (
    .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .instr_valid, .instr_op, .instr_faddr,
    .instr_access, .instr_dest, .instr_src_full, .instr_dst_full, .instr_target, .instr_ready,
    .instr_done, .mem_addr, .mem_re, .mem_we, .pc_target, .pc_load, .alu_flags, .acc
);

/* File: sim/afd_core_bench.sv */
// Self-checking bench for the core.
// Assumes the memory model answers reads a cycle late.
`timescale 1ns/10ps
`include "afd_params.svh"

module afd_core_bench;
    import afd_pkg::*;
    logic        clk_sys = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        instr_valid = 1'b0, instr_access = 1'b0, instr_dest = 1'b0;
    logic        instr_ready, instr_done, mem_re, mem_we, pc_load;
    logic [2:0]  reg_addr = 3'h0, instr_bit = 3'h0;
    logic [7:0]  reg_wdata = 8'h00, instr_faddr = 8'h00, instr_lit = 8'h00;
    logic [7:0]  reg_rdata, mem_wdata, mem_rdata, acc, w_data;
    logic [11:0] instr_src_full = 12'h000, instr_dst_full = 12'h000, index_base = 12'h000;
    logic [11:0] mem_addr, w_addr;
    logic [19:0] instr_target = 20'h0_0000, pc_target, pc_seen;
    logic [4:0]  alu_flags, f0;
    afd_op_t     instr_op = OP_NOP;
    int          err_count = 0, total_checks = 0, w_cnt = 0, w0;
    logic [15:0] t_in [6] = '{16'h7F01, 16'hFF01, 16'h8080, 16'h0305, 16'h0503, 16'h0180};
    logic [7:0]  t_res [6] = '{8'h80, 8'h00, 8'h00, 8'h02, 8'hFE, 8'h7F};
    logic [4:0]  t_flg [6] = '{5'h1A, 5'h07, 5'h0D, 5'h03, 5'h10, 5'h09};

    always #5 clk_sys = ~clk_sys;

    afd_core afd_core_inst (
        .clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .instr_valid,
        .instr_op, .instr_faddr, .instr_access, .instr_dest, .instr_bit, .instr_lit,
        .instr_src_full, .instr_dst_full, .instr_target, .index_base, .instr_ready,
        .instr_done, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata, .pc_target,
        .pc_load, .alu_flags, .acc
    );
    afd_mem_model afd_mem_model_inst (
        .clk_sys, .mem_addr, .mem_re, .mem_we, .mem_wdata, .mem_rdata
    );

    always @(posedge clk_sys) begin
        if (mem_we) begin
            w_cnt++;
            w_addr = mem_addr;
            w_data = mem_wdata;
        end
        if (pc_load) begin
            pc_seen = pc_target;
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic end_sim();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(string n, logic [19:0] e, logic [19:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cf(logic [4:0] e);
        chk("alu_flags", {15'h0000, e}, {15'h0000, alu_flags});
    endtask
    task automatic wr(logic [2:0] a, logic [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [2:0] a, logic [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rdata", {12'h000, e}, {12'h000, reg_rdata});
    endtask
    task automatic run(afd_op_t o, logic [7:0] fa, logic a, logic d, logic [7:0] l);
        int n = 0;
        @(posedge clk_sys);
        instr_valid <= 1'b1;
        instr_op <= o;
        instr_faddr <= fa;
        instr_access <= a;
        instr_dest <= d;
        instr_lit <= l;
        do begin
            @(posedge clk_sys) n++;
        end while (instr_ready !== 1'b1 && n < 20);
        instr_valid <= 1'b0;
        do begin
            @(posedge clk_sys) n++;
        end while (instr_done !== 1'b1 && n < 30);
        if (instr_done !== 1'b1) begin
            chk("instr_done", 20'h0_0001, {19'h0_0000, instr_done});
            end_sim();
        end
        #1;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(`AFD_REG_FLAGS, 8'h00);
        rd(`AFD_REG_ACC, 8'h00);
        rd(3'h7, 8'h00);
        for (int i = 0; i < 6; i++) begin
            wr(`AFD_REG_ACC, t_in[i][15:8]);
            run((i < 3) ? OP_ADD_LW : OP_SUB_LW, 8'h00, 1'b0, 1'b0, t_in[i][7:0]);
            chk("acc", {12'h000, t_res[i]}, {12'h000, acc});
            cf(t_flg[i]);
        end
        w0 = w_cnt;
        wr(`AFD_REG_ACC, 8'h01);
        run(OP_ADD_WF, 8'hF0, 1'b0, 1'b1, 8'h00);
        cf(5'h00);
        wr(`AFD_REG_FLAGS, 8'h1B);
        run(OP_CLR_F, 8'hF0, 1'b0, 1'b1, 8'h00);
        cf(5'h1F);
        chk("write count", w0, w_cnt);
        wr(`AFD_REG_FLAGS, 8'h00);
        instr_bit <= 3'h3;
        run(OP_BIT_SET, 8'hF0, 1'b0, 1'b1, 8'h00);
        cf(5'h08);
        wr(`AFD_REG_BANK, 8'h03);
        wr(`AFD_REG_ACC, 8'h10);
        run(OP_ACC_STORE, 8'h25, 1'b1, 1'b1, 8'h00);
        chk("store addr", 20'h0_0325, {8'h00, w_addr});
        cf(5'h08);
        run(OP_ADD_WF, 8'h25, 1'b1, 1'b1, 8'h00);
        chk("write data", 20'h0_0020, {12'h000, w_data});
        w0 = w_cnt;
        run(OP_ADD_WF, 8'h25, 1'b0, 1'b0, 8'h00);
        chk("acc", 20'h0_0035, {12'h000, acc});
        chk("write count", w0, w_cnt);
        rd(`AFD_REG_ADDR_HI, 8'h00);
        f0 = alu_flags;
        run(OP_NIB_SWAP, 8'h85, 1'b0, 1'b1, 8'h00);
        chk("swap addr", 20'h0_0F85, {8'h00, w_addr});
        chk("swap data", 20'h0_0058, {12'h000, w_data});
        instr_src_full <= 12'h325;
        instr_dst_full <= 12'h1AB;
        run(OP_FULL_MOVE, 8'h00, 1'b0, 1'b0, 8'h00);
        chk("move addr", 20'h0_01AB, {8'h00, w_addr});
        chk("move data", 20'h0_0020, {12'h000, w_data});
        cf(f0);
        wr(`AFD_REG_CTRL, 8'h01);
        index_base <= 12'h200;
        run(OP_ADD_WF, 8'h10, 1'b0, 1'b0, 8'h00);
        chk("acc", 20'h0_0045, {12'h000, acc});
        rd(`AFD_REG_ADDR_HI, 8'h02);
        wr(`AFD_REG_CTRL, 8'h00);
        instr_target <= 20'hA_BCDE;
        run(OP_JUMP, 8'h00, 1'b0, 1'b0, 8'h00);
        chk("pc_target", 20'hA_BCDE, pc_seen);
        f0 = alu_flags;
        run(OP_NOP, 8'hF0, 1'b0, 1'b1, 8'h00);
        cf(f0);
        end_sim();
    end
endmodule
